/* File: rtl/xor_dirload_sub_execute.v */
// decode and execute for direction load, xor and subtract instructions
//
// Operation
// - direction load copies accumulator, flags untouched
// - xor literal into accumulator, zero flag only
// - xor accumulator with file register, zero only
// - destination bit picks accumulator or file
// - smaller file operand gives wrapped result, carry clear
// - equal operands give zero, carry set
// - subtract file minus accumulator, set carry/dc/zero
`timescale 1ns/1ps
`include "xor_dirload_sub_defines.vh"

module xor_dirload_sub_execute (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire        instr_valid,
    input  wire [11:0] instr,
    input  wire [7:0]  file_rdata,
    output wire [4:0]  file_addr,
    output reg         file_we,
    output reg  [7:0]  file_wdata,
    output wire [7:0]  accum,
    output wire        carry_flag,
    output wire        digit_carry_flag,
    output wire        zero_flag,
    output wire [7:0]  port_a_direction,
    output wire [7:0]  port_b_direction,
    output wire [7:0]  port_c_direction
);

// =====================================================================
// architectural registers
reg  [7:0] accum_r;
reg  [7:0] accum_nxt;
reg        carry_r;
reg        carry_nxt;
reg        digit_carry_r;
reg        digit_carry_nxt;
reg        zero_r;
reg        zero_nxt;
reg  [7:0] dir_a_r;
reg  [7:0] dir_a_nxt;
reg  [7:0] dir_b_r;
reg  [7:0] dir_b_nxt;
reg  [7:0] dir_c_r;
reg  [7:0] dir_c_nxt;

// =====================================================================
// outputs
assign accum            = accum_r;
assign carry_flag       = carry_r;
assign digit_carry_flag = digit_carry_r;
assign zero_flag        = zero_r;
assign port_a_direction = dir_a_r;
assign port_b_direction = dir_b_r;
assign port_c_direction = dir_c_r;

// =====================================================================
// decode
// file reads are combinational: the register file answers within
// the same cycle, so every instruction finishes in one clock
wire [8:0] op_hi9    = instr[11:3];
wire [5:0] op_hi6    = instr[11:6];
wire [3:0] op_hi4    = instr[11:8];
wire [7:0] literal   = instr[7:0];
wire       dest_file = instr[`DEST_BIT];
wire [2:0] dir_sel   = instr[`DIR_SEL_MSB:0];

// selectors outside 5..7 are refused, the load then does nothing
wire dir_sel_ok = (dir_sel == `DIR_SEL_A) ||
                  (dir_sel == `DIR_SEL_B) ||
                  (dir_sel == `DIR_SEL_C);

wire is_dirload = instr_valid && (op_hi9 == `OPC_DIRLOAD_HI) &&
                  dir_sel_ok;
wire is_xorlit  = instr_valid && (op_hi4 == `OPC_XORLIT_HI);
wire is_xorfile = instr_valid && (op_hi6 == `OPC_XORFILE_HI);
wire is_subfile = instr_valid && (op_hi6 == `OPC_SUBFILE_HI);

assign file_addr = instr[`FILE_MSB:0];

// =====================================================================
// datapath
wire [7:0] xorlit_res  = accum_r ^ literal;
wire [7:0] xorfile_res = accum_r ^ file_rdata;
// add the inverted subtrahend plus one; carry out means no borrow
wire [8:0] sub_full = {1'b0, file_rdata} + {1'b0, ~accum_r}
                      + 9'h001;
wire [4:0] sub_low  = {1'b0, file_rdata[3:0]} + {1'b0, ~accum_r[3:0]}
                      + 5'h01;
wire [7:0] sub_res  = sub_full[7:0];

wire xorlit_zero  = (xorlit_res == 8'h00);
wire xorfile_zero = (xorfile_res == 8'h00);
wire sub_zero     = (sub_res == 8'h00);

// =====================================================================
// file write-back
// write-back to the register file is a same-cycle strobe
always @* begin
    file_we    = 1'b0;
    file_wdata = 8'h00;
    if (is_xorfile && dest_file) begin
        file_we    = 1'b1;
        file_wdata = xorfile_res;
    end else if (is_subfile && dest_file) begin
        file_we    = 1'b1;
        file_wdata = sub_res;
    end
end

// =====================================================================
// accumulator next value
always @* begin
    accum_nxt = accum_r;
    if (is_xorlit) begin
        accum_nxt = xorlit_res;
    end else if (is_xorfile && !dest_file) begin
        accum_nxt = xorfile_res;
    end else if (is_subfile && !dest_file) begin
        accum_nxt = sub_res;
    end
end

// =====================================================================
// status flags next value
// the opcode decodes are exclusive, so the priority order is free
always @* begin
    zero_nxt = zero_r;
    if (is_xorlit) begin
        zero_nxt = xorlit_zero;
    end else if (is_xorfile) begin
        zero_nxt = xorfile_zero;
    end else if (is_subfile) begin
        zero_nxt = sub_zero;
    end
end

// xor and direction load leave both carries alone
always @* begin
    carry_nxt       = carry_r;
    digit_carry_nxt = digit_carry_r;
    if (is_subfile) begin
        carry_nxt       = sub_full[8];
        digit_carry_nxt = sub_low[4];
    end
end

// =====================================================================
// direction registers next value
always @* begin
    dir_a_nxt = dir_a_r;
    dir_b_nxt = dir_b_r;
    dir_c_nxt = dir_c_r;
    if (is_dirload) begin
        case (dir_sel)
            `DIR_SEL_A: begin
                dir_a_nxt = accum_r;
            end
            `DIR_SEL_B: begin
                dir_b_nxt = accum_r;
            end
            `DIR_SEL_C: begin
                dir_c_nxt = accum_r;
            end
            default: begin
                dir_a_nxt = dir_a_r;
            end
        endcase
    end
end

// =====================================================================
// state registers
always @(posedge ref_clk) begin
    if (!rstn) begin
        accum_r <= `ACCUM_RST;
    end else begin
        accum_r <= accum_nxt;
    end
end

always @(posedge ref_clk) begin
    if (!rstn) begin
        carry_r <= `FLAG_RST;
    end else begin
        carry_r <= carry_nxt;
    end
end

always @(posedge ref_clk) begin
    if (!rstn) begin
        digit_carry_r <= `FLAG_RST;
    end else begin
        digit_carry_r <= digit_carry_nxt;
    end
end

always @(posedge ref_clk) begin
    if (!rstn) begin
        zero_r <= `FLAG_RST;
    end else begin
        zero_r <= zero_nxt;
    end
end

// directions reset to all inputs so no pin drives before software
always @(posedge ref_clk) begin
    if (!rstn) begin
        dir_a_r <= `DIR_RST;
    end else begin
        dir_a_r <= dir_a_nxt;
    end
end

always @(posedge ref_clk) begin
    if (!rstn) begin
        dir_b_r <= `DIR_RST;
    end else begin
        dir_b_r <= dir_b_nxt;
    end
end

always @(posedge ref_clk) begin
    if (!rstn) begin
        dir_c_r <= `DIR_RST;
    end else begin
        dir_c_r <= dir_c_nxt;
    end
end

endmodule

/* File: include/xor_dirload_sub_defines.vh */
// constants for the xor / direction-load / subtract execute block
`ifndef XOR_DIRLOAD_SUB_DEFINES_VH
`define XOR_DIRLOAD_SUB_DEFINES_VH

// opcode patterns (12-bit instruction word)
`define OPC_DIRLOAD_HI   9'h000
`define OPC_XORLIT_HI    4'hF
`define OPC_XORFILE_HI   6'h06
`define OPC_SUBFILE_HI   6'h02

// field positions
`define DEST_BIT         5
`define FILE_MSB         4
`define DIR_SEL_MSB      2

// direction register selectors
`define DIR_SEL_A        3'h5
`define DIR_SEL_B        3'h6
`define DIR_SEL_C        3'h7

// reset values
`define ACCUM_RST        8'h00
`define DIR_RST          8'hFF
`define FLAG_RST         1'b0

`endif

/* File: test/xor_dirload_sub_execute_monitor.sv */
// assertions on the execute block ports
`timescale 1ns/1ps
module exec_monitor (
    input wire        ref_clk,
    input wire        rstn,
    input wire        instr_valid,
    input wire        file_we,
    input wire        zero_flag,
    input wire        carry_flag,
    input wire        digit_carry_flag,
    input wire [11:0] instr,
    input wire [7:0]  file_rdata,
    input wire [7:0]  file_wdata,
    input wire [7:0]  accum,
    input wire [7:0]  port_b_direction
);
    wire xl = instr_valid && instr[11:8] == 4'hF;
    wire xf = instr_valid && instr[11:6] == 6'h06;
    wire sb = instr_valid && instr[11:6] == 6'h02;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_xor_lit: assert property (xl |=>
        accum == ($past(accum) ^ $past(instr[7:0]))) else $error("xor lit");
    a_xor_file: assert property (xf && !instr[5] |=>
        accum == ($past(accum) ^ $past(file_rdata))) else $error("xor file");
    a_xor_dest: assert property (xf && instr[5] |->
        file_we && file_wdata == (accum ^ file_rdata)) else $error("xor dest");
    a_xor_zero: assert property (xl || xf && !instr[5] |=>
        zero_flag == (accum == 8'h00)) else $error("xor zero");
    a_xor_carry: assert property (xl || xf |=>
        $stable({carry_flag, digit_carry_flag})) else $error("xor carry");
    a_sub_carry: assert property (sb |=>
        carry_flag == ($past(file_rdata) >= $past(accum))) else $error("carry");
    a_sub_dest: assert property (sb && instr[5] |->
        file_we && file_wdata == file_rdata - accum) else $error("sub dest");
    a_dir_load: assert property (instr_valid && instr == 12'h006 |=>
        port_b_direction == $past(accum) && $stable(zero_flag)) else $error("dir");
    cover property (sb && file_rdata == accum);
    cover property (xf && instr[5]);
    cover property (instr_valid && instr == 12'h006);
endmodule
bind xor_dirload_sub_execute exec_monitor u_exec_monitor (.*);

/* File: test/xor_dirload_sub_execute_tb.sv */
// random self-checking bench for the execute block
`timescale 1ns/1ps
module xor_dirload_sub_execute_tb;
    reg         ref_clk, rstn, instr_valid, xl, xf, sb, wb;
    reg  [11:0] instr;
    reg  [7:0]  file_rdata, ea, r;
    reg  [15:0] s;
    reg  [23:0] ed;
    reg  [2:0]  ef;
    wire [7:0]  file_wdata, accum, port_a_direction, port_b_direction;
    wire [7:0]  port_c_direction;
    wire [4:0]  file_addr;
    wire        file_we, carry_flag, digit_carry_flag, zero_flag;
    integer     error_cnt = 0, comparisons = 0;
    integer     i;
    xor_dirload_sub_execute u_xor_dirload_sub_execute (.*);
    function [15:0] lfsr(input [15:0] v);
        lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // expected result of the three computing instructions
    function [7:0] exp_result(input [11:0] op, input [7:0] w,
                              input [7:0] f);
        exp_result = op[11:8] == 4'hF ? w ^ op[7:0] :
                     op[11:6] == 6'h06 ? w ^ f : f - w;
    endfunction
    // hand-picked corners: literal xor, equal subtracts, load port b
    function [11:0] corner(input [1:0] n);
        corner = n == 2'h0 ? 12'hFAF : n == 2'h1 ? 12'h0A3 :
                 n == 2'h2 ? 12'h083 : 12'h006;
    endfunction
    task chk(input [31:0] g, input [31:0] e);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("errors %0d comparisons %0d", error_cnt, comparisons);
            if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        ref_clk = 0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        {rstn, instr_valid, instr, file_rdata, ea, ef} = 0;
        s = 51;
        ed = 24'hFFFFFF;
        repeat (12) @(posedge ref_clk);
        #1 rstn = 1;
        for (i = 0; i < 600; i = i + 1) begin
            s = lfsr(s);
            instr = s[1] ? {s[0] ? 6'h02 : 6'h06, s[15:10]} :
                    s[0] ? {4'hF, s[15:8]} : {9'h000, s[14:12]};
            // equal operands often, to reach the zero-with-carry corner
            file_rdata = s[2] ? ea : s[11:4];
            instr_valid = s[3] | s[4];
            if (i < 4) begin
                {instr_valid, file_rdata} = {1'b1, ea};
                instr = corner(i[1:0]);
            end
            #40 xl = instr_valid & instr[11:8] == 4'hF;
            xf = instr_valid & instr[11:6] == 6'h06;
            sb = instr_valid & instr[11:6] == 6'h02;
            r = exp_result(instr, ea, file_rdata);
            wb = (xf | sb) & instr[5];
            chk({file_addr, file_we, file_wdata}, {instr[4:0], wb, wb ? r : 8'h00});
            if (xl | xf | sb) ef[0] = r == 8'h00;
            if (sb) ef[2:1] = {file_rdata >= ea, file_rdata[3:0] >= ea[3:0]};
            if (instr_valid & instr[11:3] == 9'h000 & instr[2:0] > 4)
                ed[8 * (7 - instr[2:0]) +: 8] = ea;
            if ((xl | xf | sb) & ~wb) ea = r;
            @(posedge ref_clk);
            #1 chk(accum, ea);
            chk({carry_flag, digit_carry_flag, zero_flag}, ef);
            chk({port_a_direction, port_b_direction, port_c_direction}, ed);
        end
        print_verdict;
    end
endmodule
